// *** hw/char_code_mapper_8b10b.sv ***
// 8b/10b character mapper: parallel bytes to serial characters and back
// assumes host logic on i_clk; i_rx_serial arrives from the remote link
`timescale 1ns/1ps

// Behaviour
// (R1) encode each byte, shift ten bits out
// (R2) collect ten bits, decode data characters
// (R3) all 256 bytes plus special characters
// (R4) parallel bit 0 is code letter A
// (R5) a-h follow A-H, i and j derived
// (R6) select input marks special or data
// (R7) name Dxx.y from EDCBA and HGF
// (R8) D5.2 encodes to 1010010101
// (R9) comma pattern sets receive word alignment
// (R10) half-rate reference captures on both edges
// (R11) character clock stays at character rate
// (R12) half-rate receive data valid on both edges
// (R13) unit interval from reference and rate
// (R14) send a,b,c,d,e,i,f,g,h,j order
// (R15) variant by running disparity, then update
// (R16) flag violation, still update running disparity
// (R17) one registered character per character period
module char_code_mapper_8b10b
(
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_b,
  input  wire logic [code_map_pkg::BYTE_W-1:0]   i_tx_data,
  input  wire logic                              i_special_char_select,
  input  wire logic                              i_tx_ref_half_rate,
  input  wire logic                              i_tx_capture_clock_select,
  input  wire logic                              i_rx_half_rate_select,
  input  wire logic                              i_rx_serial,
  output logic                                   o_tx_serial,
  output logic                                   o_tx_taken,
  output logic                                   o_tx_k_err,
  output logic                                   o_tx_char_clock_out,
  output logic                                   o_reference_clock,
  output logic [code_map_pkg::BYTE_W-1:0]        o_rx_data,
  output logic                                   o_rx_k,
  output logic                                   o_rx_code_err,
  output logic                                   o_rx_valid,
  output logic                                   o_rx_aligned,
  output logic                                   o_rx_recovered_clock_out_a,
  output logic                                   o_rx_recovered_clock_out_c
);
  import code_map_pkg::*;

  code_if cif ();

  code_unit u_code
  (
    .cif (cif)
  );

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [3:0]        tx_cnt;
  logic [3:0]        next_tx_cnt;
  logic [CODE_W-1:0] tx_sh;
  logic [CODE_W-1:0] next_tx_sh;
  logic              tx_rd;
  logic              next_tx_rd;
  logic              next_tx_serial;
  logic              next_tx_taken;
  logic              next_tx_k_err;
  logic              next_char_clk;
  logic              next_ref_clk;
  logic              tx_tick;
  logic              tx_load;

  // bit slot counter, reference edges and character capture
  always_comb
  begin
    tx_tick = (tx_cnt == CHAR_LAST);
    next_tx_cnt = tx_tick ? CNT_RESET : tx_cnt + 4'h1;                    // R13
    // full rate: reference rises at each boundary; half rate: it toggles there
    next_ref_clk = i_tx_ref_half_rate ? (tx_tick ? !o_reference_clock : o_reference_clock)
                                      : (next_tx_cnt < REF_HIGH_SLOTS);   // R13
    // both reference edges land on boundaries in half-rate mode
    tx_load = i_tx_capture_clock_select ? tx_tick
            : (tx_tick && (i_tx_ref_half_rate || !o_reference_clock));   // R10 R17
    cif.enc_byte = i_tx_data;                                             // R4
    cif.enc_k = i_special_char_select;                                    // R6
    cif.enc_rd = tx_rd;
    next_tx_sh = tx_load ? cif.enc_code : {tx_sh[CODE_W-2:0], 1'b0};      // R1
    next_tx_serial = next_tx_sh[CODE_W-1];                                // R14
    next_tx_rd = tx_load ? cif.enc_rd_next : tx_rd;                       // R15
    next_tx_taken = tx_load;
    next_tx_k_err = tx_load ? cif.enc_k_bad : o_tx_k_err;
    next_char_clk = (next_tx_cnt < CHAR_CLK_HIGH);                        // R11
  end

  // transmit registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      tx_cnt <= CNT_RESET;
      tx_sh <= '0;
      tx_rd <= RD_RESET;
      o_tx_serial <= 1'b0;
      o_tx_taken <= 1'b0;
      o_tx_k_err <= 1'b0;
      o_tx_char_clock_out <= 1'b1;
      o_reference_clock <= 1'b1;
    end
    else
    begin
      tx_cnt <= next_tx_cnt;
      tx_sh <= next_tx_sh;
      tx_rd <= next_tx_rd;
      o_tx_serial <= next_tx_serial;
      o_tx_taken <= next_tx_taken;
      o_tx_k_err <= next_tx_k_err;
      o_tx_char_clock_out <= next_char_clk;
      o_reference_clock <= next_ref_clk;
    end
  end

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic              rx_meta;
  logic              rx_bit;
  logic [CODE_W-1:0] rx_sh;
  logic [CODE_W-1:0] rx_window;
  logic [3:0]        rx_cnt;
  logic [3:0]        next_rx_cnt;
  logic              rx_rd;
  logic              next_rx_rd;
  logic              comma_now;
  logic              rx_done;
  logic              next_aligned;
  logic [BYTE_W-1:0] next_rx_data;
  logic              next_rx_k;
  logic              next_rx_err;
  logic              next_clk_a;

  // serial input synchroniser
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rx_meta <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      rx_meta <= i_rx_serial;
      rx_bit <= rx_meta;
    end
  end

  // framing on comma, decode at each character boundary
  always_comb
  begin
    rx_window = {rx_sh[CODE_W-2:0], rx_bit};
    comma_now = (rx_window[9:3] == COMMA_NEG) || (rx_window[9:3] == COMMA_POS);   // R9
    rx_done = comma_now || (o_rx_aligned && rx_cnt == CHAR_LAST);                 // R2
    next_rx_cnt = rx_done || rx_cnt == CHAR_LAST ? CNT_RESET : rx_cnt + 4'h1;     // R9
    next_aligned = o_rx_aligned || comma_now;                                     // R9
    cif.dec_code = rx_window;
    cif.dec_rd = rx_rd;
    next_rx_rd = rx_done ? cif.dec_rd_next : rx_rd;                               // R16
    next_rx_data = rx_done ? cif.dec_byte : o_rx_data;                            // R17
    next_rx_k = rx_done ? cif.dec_k : o_rx_k;
    next_rx_err = rx_done ? cif.dec_err : o_rx_code_err;                          // R16
    // half rate: toggle per character so both edges frame data
    next_clk_a = i_rx_half_rate_select ? (rx_done ? !o_rx_recovered_clock_out_a
                                                  : o_rx_recovered_clock_out_a)
                                       : (next_rx_cnt < CHAR_CLK_HIGH);           // R12
  end

  // receive registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rx_sh <= '0;
      rx_cnt <= CNT_RESET;
      rx_rd <= RD_RESET;
      o_rx_aligned <= 1'b0;
      o_rx_data <= '0;
      o_rx_k <= 1'b0;
      o_rx_code_err <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_recovered_clock_out_a <= 1'b0;
      o_rx_recovered_clock_out_c <= 1'b0;
    end
    else
    begin
      rx_sh <= rx_window;
      rx_cnt <= next_rx_cnt;
      rx_rd <= next_rx_rd;
      o_rx_aligned <= next_aligned;
      o_rx_data <= next_rx_data;
      o_rx_k <= next_rx_k;
      o_rx_code_err <= next_rx_err;
      o_rx_valid <= rx_done;
      o_rx_recovered_clock_out_a <= next_clk_a;
      o_rx_recovered_clock_out_c <= o_rx_recovered_clock_out_a;    // lags a by one bit
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence tx_gap_s;
    !tx_tick[*8] ##1 !tx_tick;
  endsequence

  AST_TX_CHAR_PERIOD: assert property (tx_tick |=> tx_gap_s ##1 tx_tick) // R17
    else $error("character boundary not every ten bits");
  AST_TX_FIRST_BIT_A: assert property (tx_load |=> o_tx_serial == $past(cif.enc_code[9])) // R1
    else $error("first serial bit is not a");
  AST_TX_SIXTH_BIT_I: assert property (tx_load |-> ##6 o_tx_serial == $past(cif.enc_code[4], 6)) // R14
    else $error("bit i not sent between e and f");
  AST_TX_RD_UPDATE: assert property (tx_load |=> tx_rd == $past(cif.enc_rd_next)) // R15
    else $error("transmit disparity not updated");
  AST_D52_VECTOR: assert property ((cif.enc_byte == 8'h45 && !cif.enc_k && !cif.enc_rd)
                                   |-> cif.enc_code == 10'h295) // R8
    else $error("D5.2 reference character wrong");
  AST_TX_CLK_HIGH: assert property ($rose(o_tx_char_clock_out) |-> o_tx_char_clock_out[*5]
                                    ##1 !o_tx_char_clock_out) // R11
    else $error("character clock high time wrong");
  AST_RX_ALIGN: assert property (comma_now |=> o_rx_aligned && rx_cnt == CNT_RESET && o_rx_valid) // R9
    else $error("comma did not align receiver");
  AST_RX_DELIVER: assert property (rx_done |=> o_rx_valid && o_rx_data == $past(cif.dec_byte)
                                   && o_rx_k == $past(cif.dec_k)) // R2
    else $error("decoded character not delivered");
  AST_RX_VIOLATION: assert property (rx_done && cif.dec_err |=> o_rx_code_err
                                     && rx_rd == $past(cif.dec_rd_next)) // R16
    else $error("violation not flagged or disparity lost");
  AST_RX_HALF_CLK: assert property (i_rx_half_rate_select && rx_done
                                    |=> $changed(o_rx_recovered_clock_out_a)) // R12
    else $error("half-rate receive clock did not toggle");

endmodule

// *** hw/code_map_pkg.sv ***
// constants, code tables and disparity helpers for the 8b/10b mapper
// assumes one 50 MHz clock where one clock cycle carries one serial bit
package code_map_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int          BYTE_W          = 8;
  localparam int          CODE_W          = 10;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          UI_NS           = 20;                          // one serial bit
  localparam int          UI_CYCLES       = (UI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          UI_PER_REF_FULL = 10;                          // full-rate reference period
  localparam int          UI_PER_REF_HALF = 20;                          // half-rate reference period
  localparam logic [3:0]  CHAR_LAST       = 4'h9;                        // last bit slot of a character
  localparam logic [3:0]  REF_HIGH_SLOTS  = 4'(UI_PER_REF_FULL / 2);     // full-rate reference high time
  localparam logic [3:0]  CHAR_CLK_HIGH   = 4'h5;                        // character clock high slots

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        RD_RESET        = 1'b0;                        // running disparity negative
  localparam logic [3:0]  CNT_RESET       = 4'h0;

  // ---------------------------------------------------------------
  // code fields: code[9:4] = abcdei, code[3:0] = fghj
  // ---------------------------------------------------------------
  localparam logic [4:0]  K28_X           = 5'h1c;
  localparam logic [2:0]  Y7              = 3'h7;
  localparam logic [5:0]  K28_SIX         = 6'h0f;
  localparam logic [5:0]  SIX_D7          = 6'h38;
  localparam logic [5:0]  SIX_POS_TIE     = 6'h07;
  localparam logic [3:0]  FOUR_A7         = 4'h7;
  localparam logic [3:0]  FOUR_POS_TIE    = 4'h3;
  localparam logic [3:0]  FOUR_NEG_TIE    = 4'hc;
  localparam logic [6:0]  COMMA_NEG       = 7'h1f;                       // 0011111 in abcdeif
  localparam logic [6:0]  COMMA_POS       = 7'h60;                       // 1100000 in abcdeif

  // 5b/6b codes for negative running disparity, abcdei msb first
  localparam logic [5:0]  SIX_TBL [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};

  // 3b/4b codes for negative running disparity, fghj msb first
  localparam logic [3:0]  FOUR_TBL [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // ---------------------------------------------------------------
  // sub-block disparity
  // ---------------------------------------------------------------
  function automatic logic six_rd(input logic [5:0] s, input logic rd);
    int n;
    n = $countones(s);
    if (n > 3 || s == SIX_POS_TIE)
      return 1'b1;
    if (n < 3 || s == SIX_D7)
      return 1'b0;
    return rd;
  endfunction

  function automatic logic four_rd(input logic [3:0] s, input logic rd);
    int n;
    n = $countones(s);
    if (n > 2 || s == FOUR_POS_TIE)
      return 1'b1;
    if (n < 2 || s == FOUR_NEG_TIE)
      return 1'b0;
    return rd;
  endfunction

endpackage

// *** hw/code_if.sv ***
// encode and decode request/answer bundle between mapper and code unit
// assumes both ends sit on the same clock; all signals are combinational
`timescale 1ns/1ps
interface code_if;
  import code_map_pkg::*;
  logic [BYTE_W-1:0] enc_byte;
  logic              enc_k;
  logic              enc_rd;
  logic [CODE_W-1:0] enc_code;
  logic              enc_rd_next;
  logic              enc_k_bad;
  logic [CODE_W-1:0] dec_code;
  logic              dec_rd;
  logic [BYTE_W-1:0] dec_byte;
  logic              dec_k;
  logic              dec_err;
  logic              dec_rd_next;

  modport mapper (output enc_byte, enc_k, enc_rd, dec_code, dec_rd,
                  input  enc_code, enc_rd_next, enc_k_bad, dec_byte, dec_k, dec_err, dec_rd_next);
  modport unit   (input  enc_byte, enc_k, enc_rd, dec_code, dec_rd,
                  output enc_code, enc_rd_next, enc_k_bad, dec_byte, dec_k, dec_err, dec_rd_next);
endinterface

// *** hw/code_unit.sv ***
// combinational 8b/10b character encoder and table-search decoder
// assumes the mapper holds running disparity and registers all results
`timescale 1ns/1ps
module code_unit
(
  code_if.unit cif
);
  import code_map_pkg::*;

  // ---------------------------------------------------------------
  // encoder function: returns {rd_next, abcdeifghj}
  // ---------------------------------------------------------------
  function automatic logic k_ok(input logic [7:0] b);
    return b[4:0] == K28_X || (b[7:5] == Y7 && (b[4:0] == 5'h17 || b[4:0] == 5'h1b ||
           b[4:0] == 5'h1d || b[4:0] == 5'h1e));
  endfunction

  function automatic logic [10:0] encode(input logic [7:0] b, input logic k_in, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic       k;
    logic       rd_mid;
    logic       alt;
    x = b[4:0];                                     // bits E..A, bit 0 is A
    y = b[7:5];                                     // bits H..F
    k = k_in && k_ok(b);
    s6 = (k && x == K28_X) ? K28_SIX : SIX_TBL[x];
    if (rd && ($countones(s6) != 3 || s6 == SIX_D7))
      s6 = ~s6;
    rd_mid = six_rd(s6, rd);
    alt = (y == Y7) && (k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    s4 = alt ? FOUR_A7 : FOUR_TBL[y];
    if (rd_mid && ($countones(s4) != 2 || s4 == FOUR_NEG_TIE))
      s4 = ~s4;
    if (k && x == K28_X && rd && $countones(s4) == 2 && s4 != FOUR_NEG_TIE && s4 != FOUR_POS_TIE)
      s4 = ~s4;
    return {four_rd(s4, rd_mid), s6, s4};
  endfunction

  // encode path: a..e and f..h follow A..E and F..H, i and j derived
  always_comb
  begin
    {cif.enc_rd_next, cif.enc_code} = encode(cif.enc_byte, cif.enc_k, cif.enc_rd);   // R5 R6 R7 R15
    cif.enc_k_bad = cif.enc_k && !k_ok(cif.enc_byte);
  end

  // decode path: search the column of the current disparity
  always_comb
  begin
    logic [10:0] e;
    logic [8:0]  idx;
    logic        hit;
    e = '0;
    idx = '0;
    hit = 1'b0;
    cif.dec_byte = '0;
    cif.dec_k = 1'b0;
    for (int i = 0; i < 512; i++)                   // R3
    begin
      idx = 9'(i);
      e = encode(idx[7:0], idx[8], cif.dec_rd);
      if (!hit && (!idx[8] || k_ok(idx[7:0])) && e[9:0] == cif.dec_code)
      begin
        hit = 1'b1;                                 // R2
        cif.dec_byte = idx[7:0];
        cif.dec_k = idx[8];
      end
    end
    cif.dec_err = !hit;                             // R16
    cif.dec_rd_next = four_rd(cif.dec_code[3:0], six_rd(cif.dec_code[9:4], cif.dec_rd));   // R16
  end

endmodule

// *** tb/char_link_partner.sv ***
// far-side link model: serialises queued characters, or loops the transmit line back
// assumes characters are queued in abcdeifghj order with bit a in bit 9
`timescale 1ns/1ps
module char_link_partner
(
  input  wire logic i_clk,
  input  wire logic i_loop,
  input  wire logic i_tx_serial,
  output logic      o_serial
);
  logic [9:0] q [$];
  logic [9:0] shift = 10'h000;
  int         left  = 0;

  initial o_serial = 1'h0;

  // one bit per cycle off the sampling edge; the idle line toggles every cycle
  always @(negedge i_clk)
  begin
    if (left == 0 && q.size() > 0)
    begin
      shift = q.pop_front();
      left  = 10;
    end
    if (i_loop)
      o_serial <= i_tx_serial;
    else if (left > 0)
    begin
      o_serial <= shift[9];
      shift    = shift << 1;
      left--;
    end
    else
      o_serial <= ~o_serial;
  end
endmodule

// *** tb/char_code_mapper_8b10b_tb.sv ***
// self-checking bench for the 8b/10b mapper: receive burst, transmit modes, loopback
// assumes the partner model drives the receive line; inputs change at the falling edge
`timescale 1ns/1ps
module char_code_mapper_8b10b_tb;
  import code_map_pkg::*;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic              clk         = 1'h0;
  logic              rst_b       = 1'h0;
  logic [BYTE_W-1:0] tx_data     = 8'h00;
  logic              sc_sel      = 1'h0;
  logic              tx_half     = 1'h0;
  logic              cap_sel     = 1'h1;
  logic              rx_half     = 1'h0;
  logic              loop        = 1'h0;
  logic              watch       = 1'h0;
  logic              first       = 1'h1;
  logic              prev_a      = 1'h0;
  logic              rx_ser;
  logic              tx_ser;
  logic              tx_taken;
  logic              tx_k_err;
  logic              char_clk;
  logic              ref_clk;
  logic [BYTE_W-1:0] rx_data;
  logic              rx_k;
  logic              rx_err;
  logic              rx_valid;
  logic              rx_aligned;
  logic              rc_a;
  logic              rc_c;
  logic [10:0]       rxq [$];
  int                bad_count   = 0;
  int                check_count = 0;

  always #10 clk = ~clk;

  char_code_mapper_8b10b dut
  (
    .i_clk                      (clk),
    .i_rst_b                    (rst_b),
    .i_tx_data                  (tx_data),
    .i_special_char_select      (sc_sel),
    .i_tx_ref_half_rate         (tx_half),
    .i_tx_capture_clock_select  (cap_sel),
    .i_rx_half_rate_select      (rx_half),
    .i_rx_serial                (rx_ser),
    .o_tx_serial                (tx_ser),
    .o_tx_taken                 (tx_taken),
    .o_tx_k_err                 (tx_k_err),
    .o_tx_char_clock_out        (char_clk),
    .o_reference_clock          (ref_clk),
    .o_rx_data                  (rx_data),
    .o_rx_k                     (rx_k),
    .o_rx_code_err              (rx_err),
    .o_rx_valid                 (rx_valid),
    .o_rx_aligned               (rx_aligned),
    .o_rx_recovered_clock_out_a (rc_a),
    .o_rx_recovered_clock_out_c (rc_c)
  );

  char_link_partner partner
  (
    .i_clk       (clk),
    .i_loop      (loop),
    .i_tx_serial (tx_ser),
    .o_serial    (rx_ser)
  );

  // ------------------------------------------------------------
  // compare, verdict and bounded waits
  // ------------------------------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // wait for the reference clock or the capture pulse to reach a level
  task automatic wait_for(input logic sel_ref, input logic v, output int n);
    n = 0;
    while ((sel_ref ? ref_clk : tx_taken) !== v)
    begin
      @(negedge clk);
      n++;
      if (n > 40)
      begin
        $display("CHECK FAILED at %0t: wait ran out", $time);
        bad_count++;
        final_report();
      end
    end
  endtask

  // present one byte, wait for its capture, gather its ten serial bits a first
  task automatic send(input logic [7:0] b, input logic k, input logic [9:0] exp, input logic kerr,
                      input logic chk);
    logic [9:0] code;
    int         n;
    tx_data = b;
    sc_sel  = k;
    wait_for(1'h0, 1'h0, n);
    wait_for(1'h0, 1'h1, n);
    if (!first)
      check(11'(n), 11'h001, "capture spacing");
    first = 1'h0;
    for (int i = 9; i >= 0; i--)
    begin
      code[i] = tx_ser;
      if (i == 9 || i == 4)
        check(11'(char_clk), 11'(i == 9), "char clock phase");
      if (i > 0)
        @(negedge clk);
    end
    if (chk)
    begin
      check(11'(code), 11'(exp), "tx code");
      check(11'(tx_k_err), 11'(kerr), "k request error");
    end
  endtask

  // high time of the internal reference, in clock cycles
  task automatic ref_high(input int exp);
    int n;
    wait_for(1'h1, 1'h0, n);
    wait_for(1'h1, 1'h1, n);
    wait_for(1'h1, 1'h0, n);
    check(11'(n), 11'(exp), "reference high time");
  endtask

  // record each delivered character with the level of recovered clock a
  always @(negedge clk)
  begin
    if (watch)
      check(11'(rc_c), 11'(prev_a), "clock c lag");
    if (watch && rx_valid === 1'h1)
      rxq.push_back({rc_a, rx_k, rx_err, rx_data});
    prev_a = rc_a;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int         n;
    int         idx;
    logic [9:0] exp_rx [6];
    exp_rx = '{10'h2bc, 10'h045, 10'h100, 10'h2bc, 10'h2bc, 10'h000};
    repeat (16) @(negedge clk);
    check(11'({tx_taken, rx_valid, rx_aligned, char_clk, ref_clk}), 11'h003, "reset values");
    rst_b   = 1'h1;
    rx_half = 1'h1;
    watch   = 1'h1;
    // K28.5-, D5.2, bad at RD+, K28.5-, K28.5+, D0.0-: far-side disparity kept
    partner.q = '{10'h0fa, 10'h295, 10'h274, 10'h0fa, 10'h305, 10'h274};
    repeat (5) @(negedge clk);
    check(11'(rx_aligned), 11'h000, "aligned early");
    n = 0;
    while (rxq.size() < 6 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    // a burst that never completes is a mismatch and ends the run
    if (rxq.size() < 6)
    begin
      $display("CHECK FAILED at %0t: receive wait ran out", $time);
      bad_count++;
      final_report();
    end
    check(11'(rx_aligned), 11'h001, "aligned");
    for (int i = 0; i < 6; i++)
    begin
      check(11'(rxq[i][9:0]), 11'(exp_rx[i]), "rx char");
      if (i > 0)
        check(11'(rxq[i][10] ^ rxq[i-1][10]), 11'h001, "clock a toggle");
    end
    watch   = 1'h0;
    rx_half = 1'h0;
    rxq.delete();
    // transmit modes: capture per character, full-rate reference, half-rate reference
    for (int m = 0; m < 3; m++)
    begin
      tx_half = (m == 2);
      cap_sel = (m == 0);
      ref_high(tx_half ? 10 : 5);
      first = 1'h1;
      send(8'h45, 1'h0, 10'h295, 1'h0, 1'h1);
      send(8'hbc, 1'h1, 10'h0fa, 1'h0, 1'h1);
      send(8'h45, 1'h0, 10'h295, 1'h0, 1'h1);
      send(8'hbc, 1'h1, 10'h305, 1'h0, 1'h1);
      send(8'h45, 1'h1, 10'h295, 1'h1, 1'h1);
    end
    // loopback: commas then every byte value, delivered back in order
    loop  = 1'h1;
    watch = 1'h1;
    first = 1'h1;
    send(8'hbc, 1'h1, 10'h000, 1'h0, 1'h0);
    send(8'hbc, 1'h1, 10'h000, 1'h0, 1'h0);
    for (int b = 0; b < 256; b++)
      send(8'(b), 1'h0, 10'h000, 1'h0, 1'h0);
    n = 0;
    while (n < 60 && !(rxq.size() > 0 && rxq[$][7:0] === 8'hff))
    begin
      @(negedge clk);
      n++;
    end
    // last looped byte never came back: count it and stop
    if (!(rxq.size() > 0 && rxq[$][7:0] === 8'hff))
    begin
      $display("CHECK FAILED at %0t: loopback wait ran out", $time);
      bad_count++;
      final_report();
    end
    idx = 0;
    while (idx < rxq.size() && rxq[idx][9:0] !== 10'h2bc)
      idx++;
    while (idx + 1 < rxq.size() && rxq[idx+1][9:0] === 10'h2bc)
      idx++;
    for (int i = 0; i < 256; i++)
    begin
      check(11'(rxq[idx+1+i][9:0]), 11'(i), "loop byte");
      check(11'(rxq[idx+1+i][10]), 11'h001, "clock a at delivery");
    end
    final_report();
  end
endmodule
